// File: hw/tsv_compositor.sv
// Video compositor top: raster timing, three scrolled background
// planes, object line buffers, priority selection and colour lookup.
// Assumes host requests and acknowledge are synchronous to i_ref_clk.
`timescale 1ns/10ps
`include "tsv_params.svh"

// Summary of operation
// [R1] All video timing comes from one 12 MHz dot rate, not CPU clocks.
// [R2] Host offsets added to raster counts move displayed items.
// [R3] Tiles are 8x8 dot cells; objects are four cells, 16x16.
// [R4] Up to 22 objects are shown at once.
// [R5] Object memory says which objects show, their colour and position.
// [R6] Fixed object priority; lower-numbered object masks higher where they overlap.
// [R7] Three background planes, each scrolled on its own.
// [R8] Tile map address is scroll value plus raster count.
// [R9] All three planes are serialised together into the selector.
// [R10] Object dots go to a line buffer, not straight to the selector.
// [R11] Two line buffers alternate: one shown, the other built.
// [R12] Each dot picks one of four sources: three planes or objects.
// [R13] Priority table ranks sources; highest present source wins.
// [R14] A priority conflict marks an object or background collision.
// [R15] One 6-bit colour code per dot leaves toward the output.
// [R16] Colour RAM maps the code to 9 bits: 64 of 512 colours.
// [R17] The host loads the colour RAM entries.
// [R18] Host reaches every video memory except the line buffers.
// [R19] Collisions stay latched until the host acknowledges them.
module tsv_compositor
   import tsv_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   input wire tsv_cpu_req_type i_cpu_req,
   input wire logic i_coll_ack,
   output logic [15:0] o_cpu_rdata,
   output logic o_cpu_rvalid,
   output logic [5:0] o_code,
   output logic [8:0] o_rgb,
   output logic o_dot_en,
   output logic o_hsync,
   output logic o_vsync,
   output logic o_blank,
   output logic [1:0] o_coll
);

   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rstn);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [15:0] pat_mem [0:2047];
   logic [9:0] map_mem [0:4095];
   logic [7:0] scr_mem [0:7];
   logic [15:0] obj_mem [0:63];
   logic [8:0] col_mem [0:63];
   logic [1:0] pri_mem [0:3];

   logic [8:0] acc_r;
   logic [8:0] acc_sum;
   logic dot_en;
   logic [8:0] h_r;
   logic [8:0] v_r;
   logic [8:0] v_two;
   logic line_end;
   logic vis;
   logic disp_sel_r;

   logic [2:0][1:0] bg_pix;
   logic [2:0][1:0] bg_pal;
   logic [3:0] lb_pix;
   logic [3:0] pres;
   logic [1:0] win_src;
   logic [1:0] best;
   logic found;
   logic [5:0] win_code;
   logic bg_conflict;
   logic [1:0] coll_set;

   logic [4:0] eng_idx;
   logic [10:0] eng_pat_addr;
   logic eng_coll;

   // ----------------------------------------------------------------
   // Dot rate
   // ----------------------------------------------------------------
   // Fractional divider: 250 MHz has no integer ratio to 12 MHz, so
   // the enable spacing runs five gaps of 21 cycles, then one of 20.
   assign acc_sum = acc_r + `TSV_DOT_MHZ;
   assign dot_en = (acc_sum >= `TSV_REF_MHZ); // [R1]

   always_ff @(posedge i_ref_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         acc_r <= `TSV_ACC_RST;
      else if (dot_en)
         acc_r <= acc_sum - `TSV_REF_MHZ;
      else
         acc_r <= acc_sum;
   end

   // ----------------------------------------------------------------
   // Raster counters
   // ----------------------------------------------------------------
   assign line_end = dot_en && (h_r == `TSV_H_LAST);
   assign vis = (h_r < `TSV_H_VIS) && (v_r < `TSV_V_VIS);

   // Dot and line counts, advanced only on the dot enable
   always_ff @(posedge i_ref_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         h_r <= `TSV_CNT_RST;
         v_r <= `TSV_CNT_RST;
      end
      else if (dot_en)
      begin
         if (h_r == `TSV_H_LAST)
         begin
            h_r <= `TSV_CNT_RST;
            if (v_r == `TSV_V_LAST)
               v_r <= `TSV_CNT_RST;
            else
               v_r <= v_r + 9'h001;
         end
         else
            h_r <= h_r + 9'h001;
      end
   end

   // Engine builds two lines ahead: next line is already built
   always_comb
   begin
      if (v_r + `TSV_LINE_AHEAD >= `TSV_V_TOTAL)
         v_two = v_r + `TSV_LINE_AHEAD - `TSV_V_TOTAL;
      else
         v_two = v_r + `TSV_LINE_AHEAD;
   end

   // Buffer swap at the end of every line
   always_ff @(posedge i_ref_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         disp_sel_r <= 1'b0;
      else if (line_end)
         disp_sel_r <= ~disp_sel_r; // [R11]
   end

   // ----------------------------------------------------------------
   // Background planes
   // ----------------------------------------------------------------
   genvar gp;
   for (gp = 0; gp < `TSV_PLANES; gp++)
   begin : g_bg // [R7]
      localparam logic [1:0] PL = 2'(gp);
      logic [7:0] bx;
      logic [7:0] by;
      logic [9:0] ment;
      logic [15:0] prow;
      // Offsets added to the raster count steer the map lookup
      assign bx = h_r[7:0] + scr_mem[{PL, 1'b0}]; // [R2]
      assign by = v_r[7:0] + scr_mem[{PL, 1'b1}]; // [R2]
      assign ment = map_mem[{PL, by[7:3], bx[7:3]}]; // [R8]
      assign prow = pat_mem[{ment[7:0], by[2:0]}]; // [R3]
      // All planes shift out in the same dot
      assign bg_pix[gp] = prow[{bx[2:0], 1'b0} +: 2]; // [R9]
      assign bg_pal[gp] = ment[9:8];
   end

   // ----------------------------------------------------------------
   // Object line engine
   // ----------------------------------------------------------------
   tsv_obj_line u_obj_line
   (
      .i_ref_clk(i_ref_clk),
      .i_rstn(i_rstn),
      .i_start(line_end),
      .i_line(v_two[7:0]),
      .i_wr_sel(~disp_sel_r),
      .o_obj_idx(eng_idx),
      .i_obj_w0(obj_mem[{eng_idx, 1'b0}]), // [R5]
      .i_obj_w1(obj_mem[{eng_idx, 1'b1}]), // [R5]
      .o_pat_addr(eng_pat_addr),
      .i_pat_row(pat_mem[eng_pat_addr]),
      .i_rd_addr(h_r[7:0]),
      .i_rd_clr(dot_en && (h_r < `TSV_H_VIS)),
      .o_rd_pix(lb_pix), // [R10]
      .o_coll(eng_coll)
   );

   // ----------------------------------------------------------------
   // Priority selection
   // ----------------------------------------------------------------
   assign pres = {lb_pix[1:0] != 2'h0, bg_pix[2] != 2'h0,
                  bg_pix[1] != 2'h0, bg_pix[0] != 2'h0}; // [R12]

   // Highest rank among present sources; ties go to the lower index
   always_comb
   begin
      win_src = 2'h0;
      best = 2'h0;
      found = 1'b0;
      for (int s = 0; s < `TSV_SOURCES; s++)
      begin
         if (pres[s] && (!found || (pri_mem[s] > best)))
         begin
            win_src = 2'(s); // [R13]
            best = pri_mem[s];
            found = 1'b1;
         end
      end
   end

   // Winning code: source, palette and dot value
   always_comb
   begin
      win_code = `TSV_BACKDROP;
      if (found)
      begin
         if (win_src == `TSV_SRC_OBJ)
            win_code = {win_src, lb_pix}; // [R12]
         else
            win_code = {win_src, bg_pal[win_src], bg_pix[win_src]};
      end
   end

   // An object dot over any background dot is a conflict
   assign bg_conflict = pres[3] && (pres[2:0] != 3'h0); // [R14]

   // ----------------------------------------------------------------
   // Collision flags
   // ----------------------------------------------------------------
   always_comb
   begin
      coll_set = 2'h0;
      coll_set[`TSV_COLL_OBJ] = eng_coll; // [R14]
      coll_set[`TSV_COLL_BG] = dot_en && vis && bg_conflict; // [R14]
   end

   // Set wins over an acknowledge in the same cycle
   always_ff @(posedge i_ref_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         o_coll <= 2'h0;
      else
         o_coll <= coll_set | (o_coll & ~{2{i_coll_ack}}); // [R19]
   end

   // ----------------------------------------------------------------
   // Video output stage
   // ----------------------------------------------------------------
   // Code and colour captured together so both stand for one dot
   always_ff @(posedge i_ref_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         o_code <= `TSV_BACKDROP;
         o_rgb <= `TSV_RGB_RST;
      end
      else if (dot_en)
      begin
         o_code <= vis ? win_code : `TSV_BACKDROP; // [R15]
         o_rgb <= vis ? col_mem[win_code] : `TSV_RGB_RST; // [R16]
      end
   end

   // Sync, blank and the dot strobe marking each new output dot
   always_ff @(posedge i_ref_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         o_dot_en <= 1'b0;
         o_hsync <= 1'b0;
         o_vsync <= 1'b0;
         o_blank <= 1'b1;
      end
      else
      begin
         o_dot_en <= dot_en; // [R15]
         if (dot_en)
         begin
            o_hsync <= (h_r >= `TSV_HS_BEG) && (h_r < `TSV_HS_END);
            o_vsync <= (v_r >= `TSV_VS_BEG) && (v_r < `TSV_VS_END);
            o_blank <= !vis;
         end
      end
   end

   // ----------------------------------------------------------------
   // Host memory access
   // ----------------------------------------------------------------
   // Line buffers have no selector, so the host cannot reach them
   always_ff @(posedge i_ref_clk)
   begin
      if (i_cpu_req.we)
      begin
         case (i_cpu_req.sel) // [R18]
            `TSV_SEL_PAT: pat_mem[i_cpu_req.addr[10:0]] <= i_cpu_req.wdata;
            `TSV_SEL_MAP: map_mem[i_cpu_req.addr] <= i_cpu_req.wdata[9:0];
            `TSV_SEL_SCR: scr_mem[i_cpu_req.addr[2:0]] <= i_cpu_req.wdata[7:0];
            `TSV_SEL_OBJ: obj_mem[i_cpu_req.addr[5:0]] <= i_cpu_req.wdata;
            `TSV_SEL_COL: col_mem[i_cpu_req.addr[5:0]] <= i_cpu_req.wdata[8:0];
            `TSV_SEL_PRI: pri_mem[i_cpu_req.addr[1:0]] <= i_cpu_req.wdata[1:0];
            default: ;
         endcase
      end
   end

   // Read answer one cycle after the request; unmapped reads give zero
   always_ff @(posedge i_ref_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         o_cpu_rvalid <= 1'b0;
         o_cpu_rdata <= 16'h0000;
      end
      else
      begin
         o_cpu_rvalid <= i_cpu_req.re;
         case (i_cpu_req.sel) // [R18]
            `TSV_SEL_PAT: o_cpu_rdata <= pat_mem[i_cpu_req.addr[10:0]];
            `TSV_SEL_MAP: o_cpu_rdata <= {6'h00, map_mem[i_cpu_req.addr]};
            `TSV_SEL_SCR: o_cpu_rdata <= {8'h00, scr_mem[i_cpu_req.addr[2:0]]};
            `TSV_SEL_OBJ: o_cpu_rdata <= obj_mem[i_cpu_req.addr[5:0]];
            `TSV_SEL_COL: o_cpu_rdata <= {7'h00, col_mem[i_cpu_req.addr[5:0]]};
            `TSV_SEL_PRI:
               o_cpu_rdata <= {14'h0000, pri_mem[i_cpu_req.addr[1:0]]};
            default: o_cpu_rdata <= 16'h0000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_dot_single;
      dot_en |=> !dot_en;
   endproperty
   a_dot_single: assert property (p_dot_single) // [R1]
      else $error("dot enable on two cycles in a row");

   property p_dot_gap;
      dot_en |-> ##[20:21] dot_en;
   endproperty
   a_dot_gap: assert property (p_dot_gap) // [R1]
      else $error("dot enable spacing off the 12 MHz rate");

   property p_h_wrap;
      line_end |=> (h_r == `TSV_CNT_RST) && (v_r != $past(v_r));
   endproperty
   a_h_wrap: assert property (p_h_wrap) // [R2]
      else $error("raster count did not wrap at line end");

   property p_swap;
      line_end |=> (disp_sel_r != $past(disp_sel_r));
   endproperty
   a_swap: assert property (p_swap) // [R11]
      else $error("line buffers did not swap at line end");

   property p_win_present;
      (dot_en && (pres != 4'h0)) |-> pres[win_src];
   endproperty
   a_win_present: assert property (p_win_present) // [R13]
      else $error("selected source not present");

   property p_coll_bg;
      (dot_en && vis && bg_conflict) |=> o_coll[`TSV_COLL_BG];
   endproperty
   a_coll_bg: assert property (p_coll_bg) // [R14]
      else $error("background conflict not flagged");

   property p_coll_hold;
      (o_coll[`TSV_COLL_OBJ] && !i_coll_ack) |=> o_coll[`TSV_COLL_OBJ];
   endproperty
   a_coll_hold: assert property (p_coll_hold) // [R19]
      else $error("collision flag lost without acknowledge");

   property p_code_out;
      dot_en |=> o_dot_en && (o_code == $past(vis ? win_code : 6'h00));
   endproperty
   a_code_out: assert property (p_code_out) // [R15]
      else $error("output code does not follow winner");

   property p_rgb_out;
      // Colour RAM is not reset, so unloaded entries must match exactly
      dot_en |=> (o_rgb === $past(vis ? col_mem[win_code] : 9'h000));
   endproperty
   a_rgb_out: assert property (p_rgb_out) // [R16]
      else $error("colour output does not follow lookup");

   c_obj_coll: cover property (eng_coll);
   c_bg_coll: cover property (dot_en && vis && bg_conflict);
   c_obj_shown: cover property (dot_en && vis && (win_src == 2'h3));

endmodule

// File: hw/tsv_params.svh
// Constants of the tile and sprite video compositor: rates, raster
// timing, host memory selectors, reset values and bit positions.
// Assumes inclusion by bare name from the design files.
`ifndef TSV_PARAMS_SVH
`define TSV_PARAMS_SVH

// ----------------------------------------------------------------
// Clock rates in MHz
// ----------------------------------------------------------------
`define TSV_REF_MHZ 9'h0FA
`define TSV_DOT_MHZ 9'h00C
`define TSV_ACC_RST 9'h000

// ----------------------------------------------------------------
// Raster timing in dots and lines
// ----------------------------------------------------------------
`define TSV_CNT_RST 9'h000
`define TSV_H_LAST 9'h17F
`define TSV_H_VIS 9'h100
`define TSV_HS_BEG 9'h12C
`define TSV_HS_END 9'h14C
`define TSV_V_LAST 9'h107
`define TSV_V_TOTAL 9'h108
`define TSV_V_VIS 9'h0E0
`define TSV_VS_BEG 9'h0F0
`define TSV_VS_END 9'h0F4
`define TSV_LINE_AHEAD 9'h002

// ----------------------------------------------------------------
// Sources, objects and output values
// ----------------------------------------------------------------
`define TSV_PLANES 3
`define TSV_SOURCES 4
`define TSV_SRC_OBJ 2'h3
`define TSV_BACKDROP 6'h00
`define TSV_RGB_RST 9'h000
`define TSV_NUM_OBJ 5'h16
`define TSV_OBJ_LAST 4'hF
`define TSV_WIPE_LAST 8'hFF
`define TSV_COLL_OBJ 0
`define TSV_COLL_BG 1

// ----------------------------------------------------------------
// Host memory selectors
// ----------------------------------------------------------------
`define TSV_SEL_PAT 3'h0
`define TSV_SEL_MAP 3'h1
`define TSV_SEL_SCR 3'h2
`define TSV_SEL_OBJ 3'h3
`define TSV_SEL_COL 3'h4
`define TSV_SEL_PRI 3'h5

`endif

// File: hw/tsv_pkg.sv
// Types shared by the video compositor modules.
// Assumes nothing beyond a SystemVerilog compiler.
package tsv_pkg;

   // Host memory access request, one cycle wide
   typedef struct packed
   {
      logic we;
      logic re;
      logic [2:0] sel;
      logic [11:0] addr;
      logic [15:0] wdata;
   } tsv_cpu_req_type;

   // Object line engine states
   typedef enum logic [1:0] {TSV_WIPE, TSV_IDLE, TSV_SCAN, TSV_DRAW}
      tsv_eng_state_type;

endpackage

// File: hw/tsv_obj_line.sv
// Object line engine with ping-pong line buffers.
// Assumes the parent supplies object words and pattern rows for the
// addresses given, combinationally, on the same clock.
`timescale 1ns/10ps
`include "tsv_params.svh"

module tsv_obj_line
   import tsv_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   input wire logic i_start,
   input wire logic [7:0] i_line,
   input wire logic i_wr_sel,
   output logic [4:0] o_obj_idx,
   input wire logic [15:0] i_obj_w0,
   input wire logic [15:0] i_obj_w1,
   output logic [10:0] o_pat_addr,
   input wire logic [15:0] i_pat_row,
   input wire logic [7:0] i_rd_addr,
   input wire logic i_rd_clr,
   output logic [3:0] o_rd_pix,
   output logic o_coll
);

   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rstn);

   tsv_eng_state_type state_r;
   logic [4:0] idx_r;
   logic [3:0] dot_r;
   logic [7:0] line_r;
   logic [7:0] wipe_r;
   logic [7:0] ry;
   logic hit;
   logic [7:0] cell_code;
   logic [1:0] pix;
   logic [8:0] wx;
   logic wr_ok;
   logic wr_en;
   logic [3:0] tgt;
   logic [1:0][3:0] rd_val;
   logic [1:0][3:0] wr_val;

   // ----------------------------------------------------------------
   // Object fetch: four 8x8 cells make one 16x16 figure
   // ----------------------------------------------------------------
   assign o_obj_idx = idx_r;
   assign ry = line_r - i_obj_w0[7:0];
   assign hit = i_obj_w0[15] && (ry[7:4] == 4'h0); // [R5]
   assign cell_code = i_obj_w1[15:8] + {6'h00, ry[3], dot_r[3]}; // [R3]
   assign o_pat_addr = {cell_code, ry[2:0]};
   assign pix = i_pat_row[{dot_r[2:0], 1'b0} +: 2];
   assign wx = {1'b0, i_obj_w1[7:0]} + {5'h00, dot_r};
   // Dots past the right edge are dropped, not wrapped
   assign wr_ok = (state_r == TSV_DRAW) && (pix != 2'h0) && !wx[8];
   assign tgt = wr_val[i_wr_sel];
   // Lower index drew first, so an occupied dot keeps it
   assign wr_en = wr_ok && (tgt[1:0] == 2'h0); // [R6]
   assign o_rd_pix = rd_val[~i_wr_sel];

   // ----------------------------------------------------------------
   // Two line buffers, one written while the other is shown
   // ----------------------------------------------------------------
   genvar gb;
   for (gb = 0; gb < 2; gb++)
   begin : g_lb
      localparam logic BUF = 1'(gb);
      logic [3:0] mem [0:255];
      // Wipe after reset, then write or clear behind the read
      always_ff @(posedge i_ref_clk)
      begin
         if (state_r == TSV_WIPE)
            mem[wipe_r] <= 4'h0;
         else if (wr_en && (i_wr_sel == BUF))
            mem[wx[7:0]] <= {i_obj_w0[9:8], pix}; // [R10] [R11]
         else if (i_rd_clr && (i_wr_sel != BUF))
            mem[i_rd_addr] <= 4'h0; // [R11]
      end
      assign rd_val[gb] = mem[i_rd_addr];
      assign wr_val[gb] = mem[wx[7:0]];
   end

   // ----------------------------------------------------------------
   // Engine sequence: scan objects 0 to 21, draw the hits
   // ----------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         state_r <= TSV_WIPE;
         idx_r <= 5'h00;
         dot_r <= 4'h0;
         line_r <= 8'h00;
         wipe_r <= 8'h00;
      end
      else
      begin
         case (state_r)
            TSV_WIPE:
            begin
               wipe_r <= wipe_r + 8'h01;
               if (wipe_r == `TSV_WIPE_LAST)
                  state_r <= TSV_IDLE;
            end
            TSV_IDLE:
            begin
               if (i_start)
               begin
                  line_r <= i_line;
                  idx_r <= 5'h00;
                  state_r <= TSV_SCAN;
               end
            end
            TSV_SCAN:
            begin
               if (idx_r == `TSV_NUM_OBJ) // [R4]
                  state_r <= TSV_IDLE;
               else if (hit)
               begin
                  dot_r <= 4'h0;
                  state_r <= TSV_DRAW;
               end
               else
                  idx_r <= idx_r + 5'h01;
            end
            TSV_DRAW:
            begin
               dot_r <= dot_r + 4'h1;
               if (dot_r == `TSV_OBJ_LAST)
               begin
                  idx_r <= idx_r + 5'h01;
                  state_r <= TSV_SCAN;
               end
            end
            default:
               state_r <= TSV_IDLE;
         endcase
      end
   end

   // Overlap of two objects, one cycle per dot
   always_ff @(posedge i_ref_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         o_coll <= 1'b0;
      else
         o_coll <= wr_ok && (tgt[1:0] != 2'h0); // [R14]
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_eng_bound;
      (i_start && state_r == TSV_IDLE) |-> ##[2:400] state_r == TSV_IDLE;
   endproperty
   a_eng_bound: assert property (p_eng_bound) // [R4]
      else $error("object line not finished in time");

endmodule

// File: test/tsv_host_model.sv
// Host processor model: loads the compositor's video memories.
// Assumes i_ref_clk runs freely and the bench calls wr and rd.
`timescale 1ns/10ps
`include "tsv_params.svh"

module tsv_host_model
   import tsv_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_cpu_rvalid,
   input wire logic [15:0] i_cpu_rdata,
   output tsv_cpu_req_type o_cpu_req
);
   // Shadow of the colour table, used for expected colours
   logic [8:0] col_m [64];

   initial o_cpu_req = '0;

   // ----------------------------------------------------------------
   // Bus cycles
   // ----------------------------------------------------------------
   // One-cycle write; released fields go to inverse, not last value
   task automatic wr(input logic [2:0] sel, input logic [11:0] addr,
      input logic [15:0] data);
      @(negedge i_ref_clk);
      o_cpu_req = {1'b1, 1'b0, sel, addr, data};
      @(negedge i_ref_clk);
      o_cpu_req = {2'b00, ~sel, ~addr, ~data};
      if (sel == `TSV_SEL_COL)
         col_m[addr[5:0]] = data[8:0];
   endtask

   // Read: select held until valid shows, since read data follows it
   task automatic rd(input logic [2:0] sel, input logic [11:0] addr,
      output logic [15:0] data, output logic ok);
      @(negedge i_ref_clk);
      o_cpu_req = {1'b0, 1'b1, sel, addr, 16'h0000};
      ok = 1'b0;
      data = 16'h0000;
      for (int n = 0; n < 4 && !ok; n++)
      begin
         @(negedge i_ref_clk);
         if (i_cpu_rvalid === 1'b1)
         begin
            ok = 1'b1;
            data = i_cpu_rdata;
            o_cpu_req = {2'b00, ~sel, ~addr, 16'hFFFF};
         end
         else
            o_cpu_req.re = 1'b0;
      end
   endtask
endmodule

// File: test/tile_sprite_video_compositor_tb_top.sv
// Bench for the video compositor: reset, then memory access table,
// dot rate, source priority, colour lookup and collision checks.
// Assumes the package, design and host model are compiled first.
`timescale 1ns/10ps
`include "tsv_params.svh"

module tile_sprite_video_compositor_tb_top
   import tsv_pkg::*;
;
   typedef struct {logic [2:0] s; logic [11:0] a; logic [15:0] w, e;}
      tsv_row_type;
   logic i_ref_clk = 1'b0;
   logic i_rstn = 1'b0;
   logic i_coll_ack = 1'b0;
   tsv_cpu_req_type req;
   logic [15:0] rdata, got;
   logic rvalid, dot_en, hsync, vsync, blank, ok;
   logic [5:0] code;
   logic [8:0] rgb;
   logic [1:0] coll;
   int err_total = 0;
   int n_checks = 0;
   int i, k, c;
   // Write then read back; narrow memories read zero-extended
   tsv_row_type rows [8] = '{'{3'h4, 12'h005, 16'h01FF, 16'h01FF},
      '{3'h4, 12'h006, 16'hFFFF, 16'h01FF},
      '{3'h2, 12'h002, 16'h1234, 16'h0034},
      '{3'h5, 12'h003, 16'hFFFF, 16'h0003},
      '{3'h1, 12'h7FF, 16'hFFFF, 16'h03FF},
      '{3'h3, 12'h001, 16'hABCD, 16'hABCD},
      '{3'h0, 12'h7FF, 16'h5A5A, 16'h5A5A},
      '{3'h6, 12'h001, 16'h1111, 16'h0000}};

   always #2 i_ref_clk = ~i_ref_clk;

   tsv_compositor dut (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
      .i_cpu_req(req), .i_coll_ack(i_coll_ack), .o_cpu_rdata(rdata),
      .o_cpu_rvalid(rvalid), .o_code(code), .o_rgb(rgb),
      .o_dot_en(dot_en), .o_hsync(hsync), .o_vsync(vsync),
      .o_blank(blank), .o_coll(coll));
   tsv_host_model u_host (.i_ref_clk(i_ref_clk), .i_cpu_rvalid(rvalid),
      .i_cpu_rdata(rdata), .o_cpu_req(req));

   // ----------------------------------------------------------------
   // Compares and verdict
   // ----------------------------------------------------------------
   task automatic chk_val(input string nm, input logic [15:0] e, g);
      n_checks++;
      if (g !== e)
      begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_flag(input string nm, input logic e, g);
      chk_val(nm, {15'h0000, e}, {15'h0000, g});
   endtask

   task automatic give_verdict;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Bounded wait for the next dot, returning cycles waited
   task automatic next_dot(output int cyc);
      cyc = 0;
      do
      begin
         @(negedge i_ref_clk);
         cyc++;
      end
      while (dot_en !== 1'b1 && cyc < 30);
      chk_flag("dot_en", 1'b1, dot_en);
   endtask

   // Skip pipeline settling, then code and colour on eight dots
   task automatic chk_dots(input logic [5:0] e);
      int cy;
      repeat (4) next_dot(cy);
      for (int d = 0; d < 8; d++)
      begin
         next_dot(cy);
         chk_flag("blank", 1'b0, blank);
         chk_val("code", {10'h000, e}, {10'h000, code});
         chk_val("rgb", {7'h00, u_host.col_m[e]}, {7'h00, rgb});
      end
   endtask

   // Run spans about 16000 cycles; cut off far beyond that
   initial
   begin
      #200000;
      err_total++;
      give_verdict();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      repeat (2) @(negedge i_ref_clk);
      chk_flag("blank", 1'b1, blank);
      chk_val("outs", 16'h0000, {code, rgb, dot_en});
      chk_val("flags", 16'h0000, {hsync, vsync, coll, rvalid});
      i_rstn = 1'b1;
      foreach (rows[r])
      begin
         u_host.wr(rows[r].s, rows[r].a, rows[r].w);
         u_host.rd(rows[r].s, rows[r].a, got, ok);
         chk_flag("rvalid", 1'b1, ok);
         chk_val("rdata", rows[r].e, got);
      end
      // Twelve dots take exactly 250 cycles at 20 or 21 each
      next_dot(c);
      k = 0;
      for (i = 0; i < 12; i++)
      begin
         next_dot(c);
         chk_flag("dot gap", 1'b1, c == 20 || c == 21);
         k += c;
      end
      chk_val("dot span", 16'h00FA, 16'(k));
      // Scene on line 0: planes 0 and 1 solid pixel 1, plane 2 empty
      for (i = 0; i < 64; i++)
      begin
         u_host.wr(`TSV_SEL_COL, 12'(i), 16'(i * 7 + 3));
         u_host.wr(`TSV_SEL_OBJ, 12'(i), 16'h0000);
      end
      for (i = 0; i < 8; i++)
      begin
         u_host.wr(`TSV_SEL_PAT, 12'(i), 16'h0000);
         u_host.wr(`TSV_SEL_PAT, 12'(8 + i), 16'h5555);
         u_host.wr(`TSV_SEL_PAT, 12'(16 + i), 16'h5555);
         u_host.wr(`TSV_SEL_SCR, 12'(i), 16'h0000);
      end
      for (i = 0; i < 32; i++)
      begin
         u_host.wr(`TSV_SEL_MAP, 12'(i), 16'h0001);
         u_host.wr(`TSV_SEL_MAP, 12'h400 + 12'(i), 16'h0201);
         u_host.wr(`TSV_SEL_MAP, 12'h800 + 12'(i), 16'h0000);
      end
      for (i = 0; i < 4; i++)
         u_host.wr(`TSV_SEL_PRI, 12'(i), 16'(2 - i + 4 * (i / 3)));
      chk_dots(6'h01);
      u_host.wr(`TSV_SEL_PRI, 12'h001, 16'h0003);
      chk_dots(6'h19);
      // No objects shown, so an acknowledge leaves no flag standing
      @(negedge i_ref_clk);
      i_coll_ack = 1'b1;
      @(negedge i_ref_clk);
      i_coll_ack = 1'b0;
      chk_val("coll", 16'h0000, {14'h0000, coll});
      // Objects 0 and 1 stacked at x 0, y 0: they meet while line 2 is
      // built, then lie over planes 0 and 1 when line 2 is shown
      for (i = 0; i < 4; i++)
         u_host.wr(`TSV_SEL_OBJ, 12'(i),
            (i % 2 == 1) ? 16'h0100 : 16'h8000);
      c = 0;
      for (k = 0; k < 9000 && coll !== 2'h1; k++)
      begin
         @(negedge i_ref_clk);
         if (hsync === 1'b1)
            c = 1;
      end
      chk_flag("hsync", 1'b1, c == 1);
      // Let the sixteen overlapping dots pass before acknowledging
      repeat (20) @(negedge i_ref_clk);
      chk_val("coll", 16'h0001, {14'h0000, coll});
      i_coll_ack = 1'b1;
      @(negedge i_ref_clk);
      i_coll_ack = 1'b0;
      chk_val("coll", 16'h0000, {14'h0000, coll});
      for (k = 0; k < 9000 && coll[1] !== 1'b1; k++)
         @(negedge i_ref_clk);
      repeat (40) @(negedge i_ref_clk);
      chk_val("coll", 16'h0003, {14'h0000, coll});
      give_verdict();
   end
endmodule
